// >>> hw/pwbt_pkg.sv
// Package: constants, register map and carrier types for the pulse-width bus timing assist
package pwbt_pkg;
  // ==========================================================================
  // Clock rates and derived tick divisors
  localparam int unsigned REF_CLK_HZ = 50_000_000;
  localparam int unsigned FAST_TICK_HZ = 5_000_000;
  localparam int unsigned SLOW_TICK_HZ = 131_000;
  localparam int unsigned FAST_DIV = REF_CLK_HZ / FAST_TICK_HZ;
  localparam int unsigned SLOW_DIV = REF_CLK_HZ / SLOW_TICK_HZ;
  localparam int unsigned BUS_BIT_RATE = 1200;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_SYNC_TMR = 8'h0c;
  localparam logic [7:0] OFS_BREAK_TMR = 8'h10;
  localparam logic [7:0] OFS_CAPTURE = 8'h14;
  localparam logic [7:0] OFS_COMPARE = 8'h18;
  localparam logic [7:0] OFS_DRIVE = 8'h1c;

  // ==========================================================================
  // Field positions
  localparam int unsigned CTRL_START_IE = 3;
  localparam int unsigned CTRL_CMP_EN = 5;
  localparam int unsigned CTRL_PWM_MODE = 6;
  localparam int unsigned CTRL_BREAK_IE = 8;
  localparam int unsigned ST_START = 0;
  localparam int unsigned ST_BREAK = 1;
  localparam int unsigned ST_CMP = 3;

  // ==========================================================================
  // Reset values
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [15:0] TIMER_RESET = 16'h0000;
  localparam logic DRIVE_RESET = 1'b1;

  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pwbt_req_s;

  typedef struct packed {
    logic pin_out;
    logic pin_oe;
  } pwbt_pin_s;
endpackage

// >>> hw/pwbt_tick.sv
// Clock-enable divider: one-cycle pulse every DIV reference clocks
`timescale 1ns/10ps
module pwbt_tick
  import pwbt_pkg::*;
#(
  parameter int unsigned DIV = 10
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  output logic tick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } pwbt_tick_state_s;

  pwbt_tick_state_s st;
  pwbt_tick_state_s next_st;

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == 16'(DIV - 1)) begin
      next_st.cnt = 16'h0000;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

  property p_tick_single;
    @(posedge ref_clk) disable iff (!arst_n) tick |=> !tick;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("tick pulse longer than one cycle");
endmodule

// >>> hw/pwbt_assist.sv
// Pulse-width serial bus timing assist: capture, compare, break width and wake logic
//
// Functional notes
// R01: Control bit 6 selects pulse-width bus mode for capture, compare and width timer.
// R02: With control bit 8 set, break timer flags an interrupt when bus returns high.
// R03: Break timer clears and runs at falling edge, stops and flags at rising edge.
// R04: Break timer advances on the 131 kHz slow tick.
// R05: Each falling bus edge in mode copies sync timer into capture register.
// R06: Sync timer runs freely in mode, never cleared by bus edges.
// R07: Sync timer advances once per 5 MHz tick in mode.
// R08: Compare enable bit 5 plus timer equal compare sets status bit 3.
// R09: Software drives the bus drive line low, timed by capture and compare.
// R10: Software adds pulse length to captured count and writes compare register.
// R11: On compare interrupt software releases the drive line high.
// R12: Master starts every bit with a falling edge, even when slave transmits.
// R13: Control bit 3 lets a falling bus edge raise a wake interrupt.
// R14: Software must mind the break enable when turning from write to read.
// R15: Frames are 19 bits at 1200 bit/s, bits coded by low width.
// R16: Slave transmitting pulls low before sync width and holds for bit width.
// R17: Bus pin is synchronised before edge detection; edges are one-cycle strobes.
// R18: Compare flag stays set until software clears it.
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
module pwbt_assist
  import pwbt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire pwbt_req_s req,
  output logic [31:0] rdata,
  input wire logic bus_in,
  output pwbt_pin_s bus_pin,
  output logic irq
);
  // ==========================================================================
  // State
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic sync3;
    logic [15:0] ctrl;
    logic [3:0] status;
    logic [3:0] mask;
    logic [15:0] sync_tmr;
    logic [15:0] break_tmr;
    logic break_run;
    logic [15:0] capture;
    logic [15:0] compare;
    logic drive;
    logic [31:0] rdata;
  } pwbt_state_s;

  pwbt_state_s st;
  pwbt_state_s next_st;
  logic fast_tick;
  logic slow_tick;
  logic fall;
  logic rise;
  logic mode;
  logic cmp_hit;
  logic [3:0] set_evt;
  logic [3:0] clr_evt;

  function automatic logic [31:0] widen16(input logic [15:0] v);
    widen16 = {16'h0000, v};
  endfunction

  function automatic logic wr_at(input pwbt_req_s r, input logic [7:0] ofs);
    wr_at = r.wr && (r.addr == ofs);
  endfunction

  // ==========================================================================
  // Rate enables
  // Slow divisor rounds down, so the break timer runs a fraction fast (well inside bit tolerance)
  pwbt_tick #(.DIV(FAST_DIV)) u_fast (  // see R07
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .tick(fast_tick)
  );

  pwbt_tick #(.DIV(SLOW_DIV)) u_slow (  // see R04
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .tick(slow_tick)
  );

  // ==========================================================================
  // Edge strobes from the synchronised pin
  assign fall = st.sync3 && !st.sync2;  // see R17
  assign rise = !st.sync3 && st.sync2;  // see R17
  assign mode = st.ctrl[CTRL_PWM_MODE];  // see R01
  // Equality lasts a whole fast-tick period, so the flag is set again for up to ten cycles
  assign cmp_hit = mode && st.ctrl[CTRL_CMP_EN] && (st.sync_tmr == st.compare);  // see R08

  always_comb begin
    set_evt = 4'h0;
    set_evt[ST_CMP] = cmp_hit;  // see R08
    set_evt[ST_BREAK] = mode && st.ctrl[CTRL_BREAK_IE] && st.break_run && rise;  // see R02
    set_evt[ST_START] = st.ctrl[CTRL_START_IE] && fall;  // see R13
    clr_evt = wr_at(req, OFS_STATUS) ? req.wdata[3:0] : 4'h0;
  end

  // ==========================================================================
  // Next state
  always_comb begin
    next_st = st;
    // Two stages settle the pin; the third only keeps the last level for edge strobes
    next_st.sync1 = bus_in;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;

    // Sync timer never clears on edges: captures are deltas on one base
    if (mode && fast_tick) begin
      next_st.sync_tmr = st.sync_tmr + 16'h0001;  // see R06
    end
    // Master's falling edge opens every bit, so each one is captured
    if (mode && fall) begin
      next_st.capture = st.sync_tmr;  // see R05, R12
    end

    if (mode && fall) begin
      next_st.break_tmr = 16'h0000;  // see R03
      next_st.break_run = 1'b1;
    end else if (mode && rise) begin
      next_st.break_run = 1'b0;  // see R03
    end else if (st.break_run && slow_tick) begin
      // 16 bits at 381 clocks a step span far more than one bit period, so no wrap mid-bit
      next_st.break_tmr = st.break_tmr + 16'h0001;  // see R04, R15
    end
    if (!mode) begin
      next_st.break_run = 1'b0;
    end

    // Set beats a simultaneous write-one-to-clear
    next_st.status = (st.status & ~clr_evt) | set_evt;  // see R18

    if (wr_at(req, OFS_CTRL)) begin
      next_st.ctrl = req.wdata[15:0];  // see R14
    end
    if (wr_at(req, OFS_MASK)) begin
      next_st.mask = req.wdata[3:0];
    end
    if (wr_at(req, OFS_COMPARE)) begin
      next_st.compare = req.wdata[15:0];  // see R10
    end
    // Drive resets high, so the pin stays released until software claims the bus
    if (wr_at(req, OFS_DRIVE)) begin
      next_st.drive = req.wdata[0];  // see R09, R11, R16
    end

    next_st.rdata = 32'h0000_0000;
    if (req.rd) begin
      unique case (req.addr)
        OFS_CTRL: next_st.rdata = widen16(st.ctrl);
        OFS_STATUS: next_st.rdata = {28'h0000000, st.status};
        OFS_MASK: next_st.rdata = {28'h0000000, st.mask};
        OFS_SYNC_TMR: next_st.rdata = widen16(st.sync_tmr);
        OFS_BREAK_TMR: next_st.rdata = widen16(st.break_tmr);
        OFS_CAPTURE: next_st.rdata = widen16(st.capture);
        OFS_COMPARE: next_st.rdata = widen16(st.compare);
        OFS_DRIVE: next_st.rdata = {31'h00000000, st.drive};
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st.sync1 <= 1'b1;
      st.sync2 <= 1'b1;
      st.sync3 <= 1'b1;
      st.ctrl <= CTRL_RESET;
      st.status <= STATUS_RESET;
      st.mask <= MASK_RESET;
      st.sync_tmr <= TIMER_RESET;
      st.break_tmr <= TIMER_RESET;
      st.break_run <= 1'b0;
      st.capture <= TIMER_RESET;
      st.compare <= TIMER_RESET;
      st.drive <= DRIVE_RESET;
      st.rdata <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs: open-drain, only ever pulls the line low
  assign rdata = st.rdata;
  assign bus_pin.pin_out = 1'b0;
  assign bus_pin.pin_oe = !st.drive;  // see R09
  assign irq = |(st.status & st.mask);

  // ==========================================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  property p_capture;
    mode && fall |=> st.capture == $past(st.sync_tmr);
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed sync timer value");  // see R05

  property p_free_run;
    mode && fast_tick && !(wr_at(req, OFS_CTRL)) |=> st.sync_tmr == $past(st.sync_tmr) + 16'h0001;
  endproperty
  a_free_run: assert property (p_free_run) else $error("sync timer did not advance");  // see R06

  property p_tmr_hold;
    !fast_tick || !mode |=> $stable(st.sync_tmr);
  endproperty
  a_tmr_hold: assert property (p_tmr_hold) else $error("sync timer moved off tick or out of mode");  // see R07

  property p_break_clear;
    mode && fall |=> st.break_tmr == 16'h0000 && st.break_run;
  endproperty
  a_break_clear: assert property (p_break_clear) else $error("break timer not restarted");  // see R03

  property p_break_stop;
    mode && rise && !fall |=> !st.break_run ##1 $stable(st.break_tmr);
  endproperty
  a_break_stop: assert property (p_break_stop) else $error("break timer kept running");  // see R03

  property p_break_irq;
    mode && st.ctrl[CTRL_BREAK_IE] && st.break_run && rise |=> st.status[ST_BREAK];
  endproperty
  a_break_irq: assert property (p_break_irq) else $error("break flag not raised");  // see R02

  property p_cmp;
    mode && st.ctrl[CTRL_CMP_EN] && st.sync_tmr == st.compare |=> st.status[ST_CMP];
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare flag not raised");  // see R08

  property p_cmp_sticky;
    st.status[ST_CMP] && !(wr_at(req, OFS_STATUS) && req.wdata[ST_CMP]) |=> st.status[ST_CMP];
  endproperty
  a_cmp_sticky: assert property (p_cmp_sticky) else $error("compare flag dropped");  // see R18

  property p_wake;
    st.ctrl[CTRL_START_IE] && fall && st.mask[ST_START] && !wr_at(req, OFS_MASK) |=> irq;
  endproperty
  a_wake: assert property (p_wake) else $error("falling edge gave no wake interrupt");  // see R13

  property p_sync;
    fall |-> !$past(bus_in, 2) && $past(bus_in, 3);
  endproperty
  a_sync: assert property (p_sync) else $error("edge strobe not from synchronised pin");  // see R17

  property p_mode_off;
    !mode |=> !st.break_run;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("break timer runs outside mode");  // see R01

  // Set, count, gating and hold checks: flags, break timer, capture and pin move for their own cause and only for it
  property p_start_flag;
    st.ctrl[CTRL_START_IE] && fall |=> st.status[ST_START];
  endproperty
  a_start_flag: assert property (p_start_flag) else $error("falling edge flag not raised");  // see R13

  property p_start_off;
    !st.ctrl[CTRL_START_IE] && !st.status[ST_START] |=> !st.status[ST_START];
  endproperty
  a_start_off: assert property (p_start_off) else $error("edge flag set while disabled");  // see R13

  property p_cmp_gate;
    !st.ctrl[CTRL_CMP_EN] && !st.status[ST_CMP] |=> !st.status[ST_CMP];
  endproperty
  a_cmp_gate: assert property (p_cmp_gate) else $error("compare flag set while disabled");  // see R08

  property p_cmp_clear;
    wr_at(req, OFS_STATUS) && req.wdata[ST_CMP] && !cmp_hit |=> !st.status[ST_CMP];
  endproperty
  a_cmp_clear: assert property (p_cmp_clear) else $error("compare flag not cleared by write");  // see R18

  property p_break_hold;
    !st.break_run && !(mode && fall) |=> $stable(st.break_tmr);
  endproperty
  a_break_hold: assert property (p_break_hold) else $error("stopped break timer changed");  // see R03

  property p_break_count;
    st.break_run && slow_tick && !(mode && (fall || rise)) |=> st.break_tmr == $past(st.break_tmr) + 16'h0001;
  endproperty
  a_break_count: assert property (p_break_count) else $error("break timer missed a slow tick");  // see R04

  property p_break_flag_off;
    !st.ctrl[CTRL_BREAK_IE] && !st.status[ST_BREAK] |=> !st.status[ST_BREAK];
  endproperty
  a_break_flag_off: assert property (p_break_flag_off) else $error("break flag set while disabled");  // see R02

  property p_capture_hold;
    !(mode && fall) |=> $stable(st.capture);
  endproperty
  a_capture_hold: assert property (p_capture_hold) else $error("capture changed without an edge");  // see R05

  property p_drive_pin;
    wr_at(req, OFS_DRIVE) |=> bus_pin.pin_oe == !$past(req.wdata[0]);
  endproperty
  a_drive_pin: assert property (p_drive_pin) else $error("pin enable does not follow drive write");  // see R09

  property p_pin_hold;
    !wr_at(req, OFS_DRIVE) |=> $stable(bus_pin.pin_oe);
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pin enable moved without a drive write");  // see R11
endmodule

// >>> verif/pwbt_master.sv
// Bus master model: pulls the open-drain bus low for a requested number of clocks
`timescale 1ns/10ps
module pwbt_master
  import pwbt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic go,
  input wire logic [15:0] low_len,
  input wire logic slave_oe,
  output logic bus_level,
  output logic busy
);
  logic [15:0] cnt;

  // Pull-up wins only while neither side pulls low
  assign bus_level = !(busy || slave_oe);

  // Every bit starts with the master pulling low; width sets the bit value
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 16'h0000;
      busy <= 1'b0;
    end else if (go && !busy) begin
      cnt <= low_len;
      busy <= 1'b1;
    end else if (cnt > 16'h0001) begin
      cnt <= cnt - 16'h0001;
    end else begin
      busy <= 1'b0;
    end
  end
endmodule

// >>> verif/pwbt_assist_bench.sv
// Self-checking bench for the pulse-width bus timing assist
`timescale 1ns/10ps
module pwbt_assist_bench
  import pwbt_pkg::*;
;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  pwbt_req_s req = '0;
  logic [31:0] rdata;
  pwbt_pin_s bus_pin;
  logic irq;
  logic bus_level;
  logic busy;
  logic go = 1'b0;
  logic [15:0] low_len = 16'h0000;
  logic [31:0] v;
  logic [31:0] c1;
  logic [31:0] c2;
  int fail_count = 0;
  int tests_run = 0;
  int cyc = 0;
  int c0 = 0;
  int ca;
  int seed;
  int len;
  int i;

  pwbt_assist dut(.ref_clk(ref_clk), .arst_n(arst_n), .req(req), .rdata(rdata), .bus_in(bus_level),
    .bus_pin(bus_pin), .irq(irq));
  pwbt_master master(.ref_clk(ref_clk), .arst_n(arst_n), .go(go), .low_len(low_len),
    .slave_oe(bus_pin.pin_oe), .bus_level(bus_level), .busy(busy));

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc <= cyc + 1;

  // ==========================================================================
  // Bus tasks and checks
  task check(string name, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task wr(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask
  task rd(logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Slow-tick phase against the edges is unknown, so one count either way is allowed
  function automatic logic [31:0] near(logic [31:0] s, logic [31:0] e);
    return ((s + 1 >= e) && (s <= e + 1)) ? e : s;
  endfunction
  task pulse(int n, bit hold);
    @(posedge ref_clk);
    c0 = cyc;
    low_len <= n[15:0];
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    // The model raises busy at this very edge, so let it settle before polling
    #1;
    for (i = 0; i < 40000 && hold && busy !== 1'b0; i++) @(posedge ref_clk);
    if (hold) repeat (6) @(posedge ref_clk);
  endtask
  task stop_test;
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge ref_clk);
    fail_count++;
    stop_test;
  end

  // ==========================================================================
  // Main sequence
  initial begin
    seed = $urandom(45217);
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    #1 check("pin_oe", bus_pin.pin_oe, 1'b0);
    check("irq", irq, 1'b0);
    check("pin_out", bus_pin.pin_out, 1'b0);
    rd(OFS_CTRL, v); check("ctrl", v, CTRL_RESET);
    rd(OFS_MASK, v); check("mask", v, MASK_RESET);
    rd(OFS_DRIVE, v); check("drive", v, DRIVE_RESET);
    @(posedge ref_clk);
    #1 check("rdata idle", rdata, 32'h0);
    wr(OFS_CAPTURE, 32'h0000ffff);
    rd(OFS_CAPTURE, v); check("capture ro", v, 32'h0);
    wr(8'h20, 32'h1);
    rd(8'h20, v); check("unmapped", v, 32'h0);
    $display("reset test done");
    // Wake edge works without the timing mode; timers stay still
    wr(OFS_CTRL, 32'h8);
    wr(OFS_MASK, 32'h1);
    pulse(200, 1);
    rd(OFS_STATUS, v); check("wake status", v, 32'h1);
    check("wake irq", irq, 1'b1);
    rd(OFS_BREAK_TMR, v); check("break off", v, 32'h0);
    rd(OFS_SYNC_TMR, v); check("sync off", v, 32'h0);
    wr(OFS_STATUS, 32'hf);
    rd(OFS_STATUS, v); check("w1c", v, 32'h0);
    $display("wake test done");
    // Received widths: random sync bit, then a zero bit
    wr(OFS_CTRL, 32'h148);
    wr(OFS_MASK, 32'h2);
    len = 2604 + $urandom % 5209;
    pulse(len, 1);
    ca = c0;
    rd(OFS_STATUS, v); check("rx status", v, 32'h3);
    check("rx irq", irq, 1'b1);
    rd(OFS_BREAK_TMR, v); check("sync width", near(v, len / 381), len / 381);
    rd(OFS_CAPTURE, c1);
    repeat ($urandom % 50) @(posedge ref_clk);
    pulse(15625, 1);
    rd(OFS_BREAK_TMR, v); check("zero width", near(v, 15625 / 381), 15625 / 381);
    rd(OFS_CAPTURE, c2);
    check("cap delta", near(c2 - c1, (c0 - ca) / 10), (c0 - ca) / 10);
    rd(OFS_SYNC_TMR, c1);
    repeat (98) @(posedge ref_clk);
    rd(OFS_SYNC_TMR, c2);
    check("sync rate", c2 - c1, 32'd10);
    $display("receive test done");
    // Transmit flow: hold the bus past the master, release on compare
    wr(OFS_STATUS, 32'hf);
    wr(OFS_MASK, 32'h8);
    wr(OFS_CTRL, 32'h168);
    pulse(5208, 0);
    wr(OFS_DRIVE, 32'h0);
    @(posedge ref_clk);
    #1 check("drive low", bus_pin.pin_oe, 1'b1);
    rd(OFS_CAPTURE, c1);
    len = 1400 + $urandom % 400;
    wr(OFS_COMPARE, c1 + len);
    for (i = 0; i < 20000 && irq !== 1'b1; i++) @(posedge ref_clk);
    check("held low", bus_level, 1'b0);
    rd(OFS_SYNC_TMR, v); check("cmp time", near(v - c1, len), len);
    rd(OFS_STATUS, v); check("cmp status", v, 32'h9);
    wr(OFS_DRIVE, 32'h1);
    @(posedge ref_clk);
    #1 check("release", bus_pin.pin_oe, 1'b0);
    wr(OFS_MASK, 32'h0);
    @(posedge ref_clk);
    #1 check("masked irq", irq, 1'b0);
    repeat (500) @(posedge ref_clk);
    rd(OFS_STATUS, v); check("sticky", v, 32'hb);
    wr(OFS_STATUS, 32'hf);
    rd(OFS_STATUS, v); check("cleared", v, 32'h0);
    $display("transmit test done");
    stop_test;
  end
endmodule
